// File: hw/smie_exec.sv
// Execution core for the logical right shift, file move and indirect load instructions.
// Assumes the decoder presents decoded operands with instr_valid and holds them until taken.
// Assumes software reaches registers over a plain port with read data one clock later.
`timescale 1ns/1ps

// What this block does
// - Shift moves source bits 7..1 into result bits 6..0, bit 7 zero.
// - Shift loads carry with source bit 0 and sets zero from result.
// - Shift destination bit 0 writes W, 1 writes back file register 0..127.
// - File move copies the register unchanged to chosen destination, sets zero.
// - File move with destination 1 rewrites same register, contents unchanged.
// - Indirect load reads the pointed byte into W and updates zero.
// - Pointer-select bit chooses which pointer and indirect access register.
// - Mode 00 preincrement, 01 predecrement, 10 postincrement, 11 postdecrement.
// - Pre modes access stepped pointer; post modes access current, then step.
// - Relative form accesses pointer plus signed offset -32..31, pointer unchanged.
// - Indirect access registers hold nothing; naming one redirects through pointer.
// - Accesses via an indirect access register use the full pointer address.
// - Pointer is 16 bits and wraps modulo 0000h..FFFFh.
// - Pointer steps alter no status flag; only moved data does.
module smie_exec #(
  parameter int MEM_ADDR_W = 8 // Decoded data memory address bits.
) (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic instr_valid, // Decoder offers an instruction.
  input wire smie_pkg::smie_op_e instr_op, // Instruction kind.
  input wire logic [6:0] instr_faddr, // File register address.
  input wire logic instr_dest, // Destination bit, 0 is W.
  input wire logic instr_psel, // Pointer select for indirect load.
  input wire smie_pkg::smie_mode_e instr_mode, // Indirect mode field.
  input wire logic instr_rel, // Indirect load uses the relative form.
  input wire logic [5:0] instr_offset, // Signed relative offset.
  output logic instr_ready, // Instruction is taken at this edge.
  output logic instr_done, // Instruction commits at this edge.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [7:0] reg_rdata, // Register read data, one clock after reg_rd.
  output logic [7:0] work_out, // Working register.
  output logic carry_out, // Carry flag.
  output logic zero_out // Zero flag.
);
  import smie_pkg::*;

  smie_mem_if mif ();

  // Control and architectural state.
  logic [7:0] ctrl;
  logic [1:0] phase;
  logic busy;
  logic [7:0] work;
  logic carry;
  logic zero;
  logic [15:0] mem_addr;
  logic [7:0] rdata_q;
  logic rd_from_mem;

  // Latched instruction, held steady for the whole instruction cycle.
  smie_op_e ir_op;
  logic [6:0] ir_faddr;
  logic ir_dest;
  logic ir_psel;
  smie_mode_e ir_mode;
  logic ir_rel;
  logic [5:0] ir_offset;

  // Phase divider: the phase counter advances while the core is enabled and runs on to the take phase once disabled.
  wire run = ctrl[CTRL_RUN_BIT];
  wire take = run && phase == PH_TAKE && instr_valid;
  wire commit = busy && phase == PH_COMMIT;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= PH_TAKE;
    end else if (run || phase != PH_TAKE) begin
      phase <= phase + 2'h1;
    end
  end

  // Taking an instruction latches its operands for the rest of the cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (take) begin
      busy <= 1'b1;
    end else if (commit) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ir_op <= OP_NONE;
      ir_faddr <= 7'h00;
      ir_dest <= 1'b0;
      ir_psel <= 1'b0;
      ir_mode <= MODE_PRE_INC;
      ir_rel <= 1'b0;
      ir_offset <= 6'h00;
    end else if (take) begin
      ir_op <= instr_op;
      ir_faddr <= instr_faddr;
      ir_dest <= instr_dest;
      ir_psel <= instr_psel;
      ir_mode <= instr_mode;
      ir_rel <= instr_rel;
      ir_offset <= instr_offset;
    end
  end

  assign instr_ready = take;
  assign instr_done = commit;

  // Operand steering. A file address that names an indirect access register is
  // sent through its pointer with a zero relative offset, so the pointer stays put.
  wire is_load = ir_op == OP_INDIRECT_LOAD;
  wire is_shift = ir_op == OP_LOGICAL_SHIFT_RIGHT;
  wire is_move = ir_op == OP_FILE_MOVE;
  wire names_indirect = ir_faddr == FADDR_INDIRECT0 || ir_faddr == FADDR_INDIRECT1;
  wire via_pointer = is_load || names_indirect;
  wire ptr_sel = is_load ? ir_psel : ir_faddr[0];
  wire ptr_rel = !is_load || ir_rel;
  wire [5:0] ptr_offset = is_load ? ir_offset : 6'h00;
  wire [15:0] ptr_eff;
  wire [15:0] ptr0;
  wire [15:0] ptr1;

  // The full pointer value becomes the data address of every indirect access.
  wire [15:0] eff_addr = via_pointer ? ptr_eff : {9'h000, ir_faddr};

  // Software register decode.
  wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
  wire wr_work = reg_wr && reg_addr == REG_WORK;
  wire wr_status = reg_wr && reg_addr == REG_STATUS;
  wire wr_ptr = reg_wr && reg_addr >= REG_PTR0_LO && reg_addr <= REG_PTR1_HI;
  wire wr_maddr_lo = reg_wr && reg_addr == REG_MEM_ADDR_LO;
  wire wr_maddr_hi = reg_wr && reg_addr == REG_MEM_ADDR_HI;
  wire wr_mdata = reg_wr && reg_addr == REG_MEM_DATA;
  wire [3:0] ptr_byte = reg_addr - REG_PTR0_LO;

  // Pointer updates happen only for the stepping forms of the indirect load.
  smie_ptr_unit u_ptr (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel(ptr_sel),
    .mode(ir_mode),
    .rel(ptr_rel),
    .offset(ptr_offset),
    .update(commit && is_load),
    .bus_wr(wr_ptr),
    .bus_sel(ptr_byte[1:0]),
    .bus_wdata(reg_wdata),
    .eff_addr(ptr_eff),
    .ptr0(ptr0),
    .ptr1(ptr1)
  );

  // Datapath. The source byte is read in the read phase and is stable by commit.
  wire [7:0] src = mif.q;
  wire [7:0] shifted = {1'b0, src[7:1]};
  wire [7:0] result = is_shift ? shifted : src;
  wire to_work = is_load || !ir_dest;
  wire to_file = (is_shift || is_move) && ir_dest;
  wire next_zero = result == 8'h00;

  // Memory port: read in the read phase, write back at commit.
  assign mif.rd_en = busy && phase == PH_READ;
  assign mif.addr = eff_addr;
  assign mif.wr_en = commit && to_file;
  assign mif.wdata = result;
  assign mif.h_addr = mem_addr;
  assign mif.h_wr = wr_mdata;
  assign mif.h_wdata = reg_wdata;

  smie_data_mem #(
    .ADDR_W(MEM_ADDR_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .mif(mif)
  );

  // Working register. A commit wins over a software write in the same cycle,
  // because losing an instruction result is worse than losing a setup write.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      work <= WORK_RST;
    end else if (commit && to_work && ir_op != OP_NONE) begin
      work <= result;
    end else if (wr_work) begin
      work <= reg_wdata;
    end
  end

  // Flags follow the moved data only; pointer steps never reach them.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      carry <= 1'b0;
      zero <= 1'b0;
    end else if (commit && ir_op != OP_NONE) begin
      zero <= next_zero;
      if (is_shift) begin
        carry <= src[0];
      end
    end else if (wr_status) begin
      carry <= reg_wdata[STAT_CARRY_BIT];
      zero <= reg_wdata[STAT_ZERO_BIT];
    end
  end

  // Control and software memory window registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      mem_addr <= MEM_ADDR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {7'h00, reg_wdata[CTRL_RUN_BIT]};
      end
      if (wr_maddr_lo) begin
        mem_addr[7:0] <= reg_wdata;
      end
      if (wr_maddr_hi) begin
        mem_addr[15:8] <= reg_wdata;
      end
    end
  end

  // Read mux; memory data comes from the memory's own read register instead.
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      REG_CTRL: rd_mux = {6'h00, busy, run};
      REG_WORK: rd_mux = work;
      REG_STATUS: rd_mux = {6'h00, zero, carry};
      REG_PTR0_LO: rd_mux = ptr0[7:0];
      REG_PTR0_HI: rd_mux = ptr0[15:8];
      REG_PTR1_LO: rd_mux = ptr1[7:0];
      REG_PTR1_HI: rd_mux = ptr1[15:8];
      REG_MEM_ADDR_LO: rd_mux = mem_addr[7:0];
      REG_MEM_ADDR_HI: rd_mux = mem_addr[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rd_from_mem <= 1'b0;
    end else begin
      rd_from_mem <= reg_rd && reg_addr == REG_MEM_DATA;
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rd_from_mem ? mif.h_q : rdata_q;
  assign work_out = work;
  assign carry_out = carry;
  assign zero_out = zero;
endmodule : smie_exec

// File: common/smie_pkg.sv
// Shared constants and types for the shift/move/indirect-load execution block.
// Assumes one 10 MHz clock (clk_sys) and a synchronous active-high reset.
package smie_pkg;

  // One instruction cycle is four clock phases: take, read, compute, commit.
  localparam int QPHASES = 4;
  localparam logic [1:0] PH_TAKE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_COMMIT = 2'h3;

  // Widths of the datapath and of instruction operands.
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int FADDR_W = 7;
  localparam int OFS_W = 6;
  localparam int REG_AW = 4;

  // File addresses that name the two indirect access registers.
  localparam logic [6:0] FADDR_INDIRECT0 = 7'h00;
  localparam logic [6:0] FADDR_INDIRECT1 = 7'h01;

  // Software register offsets on the plain register port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WORK = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_PTR0_LO = 4'h3;
  localparam logic [3:0] REG_PTR0_HI = 4'h4;
  localparam logic [3:0] REG_PTR1_LO = 4'h5;
  localparam logic [3:0] REG_PTR1_HI = 4'h6;
  localparam logic [3:0] REG_MEM_ADDR_LO = 4'h7;
  localparam logic [3:0] REG_MEM_ADDR_HI = 4'h8;
  localparam logic [3:0] REG_MEM_DATA = 4'h9;

  // Field positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_ZERO_BIT = 1;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] MEM_ADDR_RST = 16'h0000;

  // Instruction kinds handed over by the decoder.
  typedef enum logic [1:0] {
    OP_LOGICAL_SHIFT_RIGHT,
    OP_FILE_MOVE,
    OP_INDIRECT_LOAD,
    OP_NONE
  } smie_op_e;

  // Indirect mode field; declaration order gives the codes 00, 01, 10, 11.
  typedef enum logic [1:0] {
    MODE_PRE_INC,
    MODE_PRE_DEC,
    MODE_POST_INC,
    MODE_POST_DEC
  } smie_mode_e;

endpackage : smie_pkg

// File: common/smie_mem_if.sv
// Carrier between the execution core and its data memory.
// Assumes both ends run on clk_sys; the memory answers reads one clock later.
`timescale 1ns/1ps
interface smie_mem_if;
  logic rd_en; // Core read request.
  logic wr_en; // Core write request.
  logic [15:0] addr; // Core effective address.
  logic [7:0] wdata; // Core write data.
  logic [7:0] q; // Core read data, registered.
  logic [15:0] h_addr; // Software access address.
  logic h_wr; // Software write request.
  logic [7:0] h_wdata; // Software write data.
  logic [7:0] h_q; // Software read data, registered.

  modport core (output rd_en, wr_en, addr, wdata, h_addr, h_wr, h_wdata, input q, h_q);
  modport mem (input rd_en, wr_en, addr, wdata, h_addr, h_wr, h_wdata, output q, h_q);
endinterface : smie_mem_if

// File: hw/smie_data_mem.sv
// Data memory holding the file registers and all indirectly reached bytes.
// Assumes one clock; only the low ADDR_W address bits select a byte.
`timescale 1ns/1ps
module smie_data_mem #(
  parameter int ADDR_W = 8 // Number of decoded address bits.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, clears the read registers.
  smie_mem_if.mem mif // Core and software ports.
);
  import smie_pkg::*;

  logic [7:0] cells [2**ADDR_W];

  wire [ADDR_W-1:0] core_idx = mif.addr[ADDR_W-1:0];
  wire [ADDR_W-1:0] host_idx = mif.h_addr[ADDR_W-1:0];

  // The core write wins a same-cycle collision, since it commits an instruction.
  always_ff @(posedge clk_sys) begin
    if (mif.wr_en) begin
      cells[core_idx] <= mif.wdata;
    end
    if (mif.h_wr && !(mif.wr_en && core_idx == host_idx)) begin
      cells[host_idx] <= mif.h_wdata;
    end
  end

  // Read data leave from registers so the core sees stable bytes in later phases.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mif.q <= 8'h00;
      mif.h_q <= 8'h00;
    end else begin
      if (mif.rd_en) begin
        mif.q <= cells[core_idx];
      end
      mif.h_q <= cells[host_idx];
    end
  end
endmodule : smie_data_mem

// File: hw/smie_ptr_unit.sv
// Two 16-bit indirect pointer registers with effective-address arithmetic.
// Assumes the core holds sel, mode, rel and offset steady for a whole instruction.
`timescale 1ns/1ps
module smie_ptr_unit (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic sel, // Which pointer is used.
  input wire smie_pkg::smie_mode_e mode, // Indirect mode field.
  input wire logic rel, // Relative-offset form, pointer left unchanged.
  input wire logic [5:0] offset, // Signed offset for the relative form.
  input wire logic update, // Commit the stepped pointer.
  input wire logic bus_wr, // Software byte write.
  input wire logic [1:0] bus_sel, // Bit 1 pointer, bit 0 high byte.
  input wire logic [7:0] bus_wdata, // Software write data.
  output logic [15:0] eff_addr, // Effective data address.
  output logic [15:0] ptr0, // Pointer 0 value.
  output logic [15:0] ptr1 // Pointer 1 value.
);
  import smie_pkg::*;

  function automatic logic mode_is_post(input smie_mode_e m);
    return (m == MODE_POST_INC) || (m == MODE_POST_DEC);
  endfunction : mode_is_post

  function automatic logic mode_is_dec(input smie_mode_e m);
    return (m == MODE_PRE_DEC) || (m == MODE_POST_DEC);
  endfunction : mode_is_dec

  logic [15:0] ptr_q [2];

  // Sixteen-bit sums wrap on their own, which gives the modulo behaviour.
  wire [15:0] ptr_cur = sel ? ptr_q[1] : ptr_q[0];
  wire [15:0] step = mode_is_dec(mode) ? 16'hFFFF : 16'h0001;
  wire [15:0] stepped = ptr_cur + step;
  wire [15:0] ofs_ext = {{10{offset[5]}}, offset};
  wire [15:0] rel_addr = ptr_cur + ofs_ext;

  // Pre modes use the stepped value, post modes the current one.
  assign eff_addr = rel ? rel_addr : (mode_is_post(mode) ? ptr_cur : stepped);
  assign ptr0 = ptr_q[0];
  assign ptr1 = ptr_q[1];

  // Pointer steps never touch the flags; those live in the core only.
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        ptr_q[i] <= PTR_RST;
      end else if (update && !rel && sel == i[0]) begin
        ptr_q[i] <= stepped;
      end else if (bus_wr && bus_sel[1] == i[0]) begin
        if (bus_sel[0]) begin
          ptr_q[i][15:8] <= bus_wdata;
        end else begin
          ptr_q[i][7:0] <= bus_wdata;
        end
      end
    end
  end
endmodule : smie_ptr_unit

// File: testbench/smie_exec_chk.sv
// Concurrent checks on the execution block's instruction timing and flag results.
// Assumes it is bound into smie_exec and sees only that module's ports.
`timescale 1ns/1ps
module smie_exec_chk #(
  parameter int MEM_ADDR_W = 8 // Kept equal to the design's value.
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic instr_valid, // Instruction offered.
  input wire smie_pkg::smie_op_e instr_op, // Instruction kind.
  input wire logic instr_dest, // Destination bit.
  input wire logic instr_ready, // Taken pulse.
  input wire logic instr_done, // Commit pulse.
  input wire logic [7:0] work_out, // Working register.
  input wire logic carry_out, // Carry flag.
  input wire logic zero_out // Zero flag.
);
  import smie_pkg::*;
  // One clock domain; a reset abandons any instruction in flight.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // An instruction of one kind and destination, taken and then committed three clocks later.
  sequence s_exec(op, d);
    instr_ready && instr_op == op && instr_dest == d ##3 instr_done;
  endsequence
  sequence s_load;
    instr_ready && instr_op == OP_INDIRECT_LOAD ##3 instr_done;
  endsequence
  property p_done_lat;
    instr_ready |-> ##3 instr_done;
  endproperty
  property p_done_cause;
    instr_done |-> $past(instr_ready, 3);
  endproperty
  property p_ready_gap;
    instr_ready |=> !instr_ready [*3];
  endproperty
  property p_ready_valid;
    instr_ready |-> instr_valid;
  endproperty
  // Results are visible in the cycle after the commit edge.
  property p_shift_w;
    s_exec(OP_LOGICAL_SHIFT_RIGHT, 1'b0) |=> !work_out[7] && zero_out == (work_out == 8'h00);
  endproperty
  property p_shift_keep;
    s_exec(OP_LOGICAL_SHIFT_RIGHT, 1'b1) |=> $stable(work_out);
  endproperty
  property p_move_w;
    s_exec(OP_FILE_MOVE, 1'b0) |=> zero_out == (work_out == 8'h00) && $stable(carry_out);
  endproperty
  property p_move_keep;
    s_exec(OP_FILE_MOVE, 1'b1) |=> $stable(work_out) && $stable(carry_out);
  endproperty
  property p_load_z;
    s_load |=> zero_out == (work_out == 8'h00);
  endproperty
  property p_load_carry;
    s_load |=> $stable(carry_out);
  endproperty
  a_done_lat: assert property (p_done_lat) else $error("commit not three clocks after take");
  a_done_cause: assert property (p_done_cause) else $error("commit without a take");
  a_ready_gap: assert property (p_ready_gap) else $error("take inside an instruction cycle");
  a_ready_valid: assert property (p_ready_valid) else $error("take without an offer");
  a_shift_w: assert property (p_shift_w) else $error("shift result to W wrong");
  a_shift_keep: assert property (p_shift_keep) else $error("shift to file changed W");
  a_move_w: assert property (p_move_w) else $error("move to W flags wrong");
  a_move_keep: assert property (p_move_keep) else $error("move to file changed W");
  a_load_z: assert property (p_load_z) else $error("load zero flag wrong");
  a_load_carry: assert property (p_load_carry) else $error("pointer step moved carry");
endmodule : smie_exec_chk

bind smie_exec smie_exec_chk #(.MEM_ADDR_W(MEM_ADDR_W)) smie_exec_chk_i (.clk_sys(clk_sys), .rst(rst),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_dest(instr_dest), .instr_ready(instr_ready),
  .instr_done(instr_done), .work_out(work_out), .carry_out(carry_out), .zero_out(zero_out));

// File: testbench/smie_dec_model.sv
// Model of the instruction decoder that feeds the execution block.
// Assumes the bench pulses go with a packed command only while nothing is offered.
`timescale 1ns/1ps
module smie_dec_model (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic go, // Offer the command.
  input wire logic [19:0] cmd, // Op, faddr, dest, psel, mode, rel, offset.
  input wire logic instr_ready, // Block took the offer.
  output logic instr_valid, // Offer pending.
  output smie_pkg::smie_op_e instr_op, // Kind.
  output logic [6:0] instr_faddr, // File address.
  output logic instr_dest, // Destination bit.
  output logic instr_psel, // Pointer select.
  output smie_pkg::smie_mode_e instr_mode, // Mode field.
  output logic instr_rel, // Relative form.
  output logic [5:0] instr_offset // Signed offset.
);
  import smie_pkg::*;
  logic [19:0] hold;
  logic [19:0] bus;
  // Outside an offer the operands show inverted junk, so a block reading them late is caught.
  assign bus = instr_valid ? hold : ~hold;
  assign instr_op = smie_op_e'(bus[19:18]);
  assign instr_faddr = bus[17:11];
  assign instr_dest = bus[10];
  assign instr_psel = bus[9];
  assign instr_mode = smie_mode_e'(bus[8:7]);
  assign instr_rel = bus[6];
  assign instr_offset = bus[5:0];
  // The offer stands until the edge at which the block takes it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      instr_valid <= 1'b0;
      hold <= 20'h00000;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
    end else if (go) begin
      instr_valid <= 1'b1;
      hold <= cmd;
    end
  end
endmodule : smie_dec_model

// File: testbench/tb_smie_exec.sv
// Self-checking bench for the shift, file move and indirect load execution block.
// Assumes the package, the decoder model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_smie_exec;
  import smie_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [19:0] cmd = 20'h00000;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, work_out, w, rd;
  logic instr_valid, instr_ready, instr_done, instr_dest, instr_psel, instr_rel, carry_out, zero_out, c, z;
  smie_op_e instr_op;
  smie_mode_e instr_mode;
  logic [6:0] instr_faddr;
  logic [5:0] instr_offset;
  logic [7:0] m [256];
  logic [15:0] p [2];
  logic [31:0] x;
  int miscompares = 0;
  int total_checks = 0;
  integer seed = 32'h859b;

  // Clock of 100 ns period.
  always #50 clk_sys = ~clk_sys;

  smie_dec_model smie_dec_model_i (.clk_sys(clk_sys), .rst(rst), .go(go), .cmd(cmd), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_faddr(instr_faddr), .instr_dest(instr_dest),
    .instr_psel(instr_psel), .instr_mode(instr_mode), .instr_rel(instr_rel), .instr_offset(instr_offset));
  smie_exec smie_exec_i (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_faddr(instr_faddr), .instr_dest(instr_dest), .instr_psel(instr_psel), .instr_mode(instr_mode),
    .instr_rel(instr_rel), .instr_offset(instr_offset), .instr_ready(instr_ready), .instr_done(instr_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .work_out(work_out), .carry_out(carry_out), .zero_out(zero_out));

  // Register port cycles; read data is taken in the cycle after the strobe only.
  task automatic regw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : regw
  task automatic regr(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : regr
  task automatic memw(input logic [7:0] a, input logic [7:0] d);
    regw(REG_MEM_ADDR_LO, a);
    regw(REG_MEM_DATA, d);
    m[a] = d;
  endtask : memw
  task automatic setp(input logic s, input logic [15:0] v);
    regw(s ? REG_PTR1_LO : REG_PTR0_LO, v[7:0]);
    regw(s ? REG_PTR1_HI : REG_PTR0_HI, v[15:8]);
    p[s] = v;
  endtask : setp

  // Byte reached by a file operand; the two lowest names hold nothing and go through a pointer.
  function automatic logic [7:0] ea(input logic [6:0] f);
    return (f <= 7'h01) ? p[f[0]][7:0] : {1'b0, f};
  endfunction : ea

  // Works out the expected outcome, offers the instruction, waits for the commit and compares.
  task automatic run(input logic [1:0] op, input logic [6:0] f, input logic d, input logic s,
    input logic [1:0] md, input logic r, input logic [5:0] o);
    logic [15:0] a;
    logic [7:0] v;
    int n;
    v = m[ea(f)];
    a = p[s];
    case (op)
      OP_LOGICAL_SHIFT_RIGHT: begin
        c = v[0];
        v = {1'b0, v[7:1]};
        z = (v == 8'h00);
        if (d) m[ea(f)] = v;
        else w = v;
      end
      OP_FILE_MOVE: begin
        z = (v == 8'h00);
        if (d) m[ea(f)] = v;
        else w = v;
      end
      OP_INDIRECT_LOAD: begin
        if (r) a = p[s] + {{10{o[5]}}, o};
        else if (!md[1]) a = md[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
        if (!r) p[s] = md[0] ? p[s] - 16'h0001 : p[s] + 16'h0001;
        w = m[a[7:0]];
        z = (w == 8'h00);
      end
      default: ;
    endcase
    @(posedge clk_sys);
    cmd <= {op, f, d, s, md, r, o};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    @(negedge clk_sys);
    while (instr_done !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n < 20, 1'b1)
    @(posedge clk_sys);
    #1;
    `CHK(work_out, w)
    `CHK(carry_out, c)
    `CHK(zero_out, z)
    if (op == OP_INDIRECT_LOAD) begin
      regr(s ? REG_PTR1_LO : REG_PTR0_LO);
      `CHK(rd, p[s][7:0])
      regr(s ? REG_PTR1_HI : REG_PTR0_HI);
      `CHK(rd, p[s][15:8])
    end
    if (d && !op[1]) begin
      regw(REG_MEM_ADDR_LO, ea(f));
      regr(REG_MEM_DATA);
      `CHK(rd, m[ea(f)])
    end
  endtask : run

  // Prints the tally and the verdict, then ends the run.
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // A hung handshake must not stall the run; the span covers the fill plus every instruction.
  initial begin
    #(100 * 20000);
    miscompares++;
    close_out;
  end

  // Reset, register defaults, memory fill, corner cases, then random instructions.
  initial begin
    w = 8'h00;
    c = 1'b0;
    z = 1'b0;
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i != 9) begin
        regr(i[3:0]);
        `CHK(rd, 8'h00)
      end
    end
    regw(4'hC, 8'hFF);
    regr(4'hC);
    `CHK(rd, 8'h00)
    for (int i = 0; i < 256; i++) memw(i[7:0], 8'($random(seed)));
    memw(8'h05, 8'h00);
    memw(8'h06, 8'h01);
    regw(REG_CTRL, 8'h01);
    run(OP_FILE_MOVE, 7'h05, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
    run(OP_LOGICAL_SHIFT_RIGHT, 7'h06, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
    setp(1'b0, 16'hFFFF);
    run(OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b0, 2'h2, 1'b0, 6'h00);
    setp(1'b1, 16'h0000);
    run(OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b1, 2'h1, 1'b0, 6'h00);
    run(OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b1, 2'h0, 1'b1, 6'h20);
    run(OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b1, 2'h3, 1'b1, 6'h1F);
    for (int i = 0; i < 4; i++) run(OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b0, i[1:0], 1'b0, 6'h00);
    run(OP_LOGICAL_SHIFT_RIGHT, 7'h00, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
    run(OP_FILE_MOVE, 7'h01, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
    repeat (250) begin
      x = $random(seed);
      if (x[31:28] == 4'h0) setp(x[27], x[15:0]);
      run(x[1:0], x[8:2], x[9], x[10], x[12:11], x[13], x[19:14]);
      repeat (x[22:21]) @(posedge clk_sys);
    end
    close_out;
  end
endmodule : tb_smie_exec
